// ==== src/sxsalu_top.sv ====
/*
 * Execution datapath for subtract, xor and nibble swap instructions.
 * Holds the working accumulator and carry, digit carry and zero flags.
 * Assumes the decoder presents one instruction per op_valid cycle and
 * that the file register value for file_addr is present alongside.
 */
`timescale 1ns/10ps

// Notes on behaviour
// - Subtract from file computes file minus accumulator; updates carry, digit carry, zero.
// - Destination bit 0 writes result into accumulator; file register untouched.
// - Destination bit 1 writes result back to the file register, not accumulator, except for xor literal.
// - Xor literal: accumulator xor literal into accumulator, only zero flag updated.
// - Xor file: accumulator xor file, routed by destination bit, only zero flag.
// - Nibble swap exchanges nibbles of file value; no flag changes.
// - Nibble swap goes to file when destination set, else to accumulator.
module sxsalu_top
    import sxsalu_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic op_valid,
    input wire sxsalu_op_t op,
    input wire logic dest_file,
    input wire logic [6:0] file_addr,
    input wire logic [7:0] file_rdata,
    input wire logic [7:0] literal,
    output logic [7:0] acc,
    output logic carry_flag,
    output logic digit_carry_flag,
    output logic zero_flag,
    output logic file_we,
    output logic [6:0] file_waddr,
    output logic [7:0] file_wdata
);
    logic [2:0] flags;
    wire logic [7:0] result;
    wire logic [2:0] next_flags;
    wire logic to_file;
    wire logic to_acc;

    // ==========================================================
    // Result unit
    sxsalu_core u_core (
        .op(op),
        .acc(acc),
        .file_val(file_rdata),
        .literal(literal),
        .flags_in(flags),
        .result(result),
        .flags_out(next_flags)
    );

    // ==========================================================
    // Destination routing; literal form always targets accumulator
    assign to_file = op_valid && dest_file && (op != SXSALU_OP_XOR_LITERAL_ACC);
    assign to_acc = op_valid && !to_file;

    // ==========================================================
    // Accumulator and flags
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            acc <= SXSALU_ACC_RST;
            flags <= SXSALU_FLAGS_RST;
        end else if (op_valid) begin
            flags <= next_flags;
            if (to_acc) begin
                acc <= result;
            end
        end
    end

    // ==========================================================
    // File register write port, one cycle after the instruction
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            file_we <= 1'b0;
            file_waddr <= 7'h00;
            file_wdata <= 8'h00;
        end else begin
            file_we <= to_file;
            if (to_file) begin
                file_waddr <= file_addr;
                file_wdata <= result;
            end
        end
    end

    assign carry_flag = flags[SXSALU_FLAG_C];
    assign digit_carry_flag = flags[SXSALU_FLAG_DIGIT_CARRY];
    assign zero_flag = flags[SXSALU_FLAG_Z];

    // ==========================================================
    // Checks
    property p_sub_value;
        @(posedge clk_sys) disable iff (rst)
        (op_valid && op == SXSALU_OP_SUB_ACC_FROM_FILE && !dest_file)
            |=> (acc == 8'($past(file_rdata) - $past(acc)));
    endproperty
    a_sub_value: assert property (p_sub_value) else $error("subtract result wrong");

    property p_sub_file;
        @(posedge clk_sys) disable iff (rst)
        (op_valid && op == SXSALU_OP_SUB_ACC_FROM_FILE && dest_file)
            |=> (file_we
                 && file_wdata == 8'($past(file_rdata) - $past(acc))
                 && $stable(acc));
    endproperty
    a_sub_file: assert property (p_sub_file) else $error("subtract to file wrong");

    property p_acc_dest;
        @(posedge clk_sys) disable iff (rst)
        (op_valid && !dest_file) |=> !file_we;
    endproperty
    a_acc_dest: assert property (p_acc_dest) else $error("file written for acc dest");

    property p_file_dest;
        @(posedge clk_sys) disable iff (rst)
        (op_valid && dest_file && op != SXSALU_OP_XOR_LITERAL_ACC)
            |=> (file_we && file_waddr == $past(file_addr) && $stable(acc));
    endproperty
    a_file_dest: assert property (p_file_dest) else $error("file dest not honoured");

    property p_xor_lit;
        @(posedge clk_sys) disable iff (rst)
        (op_valid && op == SXSALU_OP_XOR_LITERAL_ACC)
            |=> (acc == ($past(acc) ^ $past(literal)) && zero_flag == (acc == 8'h00)
                 && $stable(carry_flag) && $stable(digit_carry_flag));
    endproperty
    a_xor_lit: assert property (p_xor_lit) else $error("xor literal wrong");

    property p_xor_file;
        @(posedge clk_sys) disable iff (rst)
        (op_valid && op == SXSALU_OP_XOR_ACC_FILE && dest_file)
            |=> (file_wdata == ($past(acc) ^ $past(file_rdata)) && $stable(carry_flag)
                 && $stable(digit_carry_flag)
                 && zero_flag == (file_wdata == 8'h00));
    endproperty
    a_xor_file: assert property (p_xor_file) else $error("xor file wrong");

    property p_swap_flags;
        @(posedge clk_sys) disable iff (rst)
        (op_valid && op == SXSALU_OP_NIBBLE_SWAP_FILE)
            |=> ($stable(carry_flag) && $stable(digit_carry_flag) && $stable(zero_flag));
    endproperty
    a_swap_flags: assert property (p_swap_flags) else $error("swap changed flags");

    property p_swap_acc;
        @(posedge clk_sys) disable iff (rst)
        (op_valid && op == SXSALU_OP_NIBBLE_SWAP_FILE && !dest_file)
            |=> (acc == {$past(file_rdata[3:0]), $past(file_rdata[7:4])});
    endproperty
    a_swap_acc: assert property (p_swap_acc) else $error("swap to acc wrong");

    property p_sub_flags;
        @(posedge clk_sys) disable iff (rst)
        (op_valid && op == SXSALU_OP_SUB_ACC_FROM_FILE)
            |=> (carry_flag == ($past(acc) <= $past(file_rdata))
                 && digit_carry_flag == ($past(acc[3:0]) <= $past(file_rdata[3:0]))
                 && zero_flag == ($past(acc) == $past(file_rdata)));
    endproperty
    a_sub_flags: assert property (p_sub_flags) else $error("subtract flags wrong");

    property p_xor_acc;
        @(posedge clk_sys) disable iff (rst)
        (op_valid && op == SXSALU_OP_XOR_ACC_FILE && !dest_file)
            |=> (acc == ($past(acc) ^ $past(file_rdata)) && zero_flag == (acc == 8'h00)
                 && $stable(carry_flag) && $stable(digit_carry_flag));
    endproperty
    a_xor_acc: assert property (p_xor_acc) else $error("xor file to acc wrong");

    property p_swap_file;
        @(posedge clk_sys) disable iff (rst)
        (op_valid && op == SXSALU_OP_NIBBLE_SWAP_FILE && dest_file)
            |=> (file_we && file_wdata == {$past(file_rdata[3:0]), $past(file_rdata[7:4])}
                 && $stable(acc));
    endproperty
    a_swap_file: assert property (p_swap_file) else $error("swap to file wrong");

    property p_lit_acc;
        @(posedge clk_sys) disable iff (rst)
        (op_valid && op == SXSALU_OP_XOR_LITERAL_ACC && dest_file)
            |=> (!file_we && acc == ($past(acc) ^ $past(literal)));
    endproperty
    a_lit_acc: assert property (p_lit_acc) else $error("xor literal left acc");

    property p_write_hold;
        @(posedge clk_sys) disable iff (rst)
        !(op_valid && dest_file && op != SXSALU_OP_XOR_LITERAL_ACC)
            |=> (!file_we && $stable(file_waddr) && $stable(file_wdata));
    endproperty
    a_write_hold: assert property (p_write_hold) else $error("file port moved");

    // ==========================================================
    // Checks on idle and reset

    property p_idle_hold;
        @(posedge clk_sys) disable iff (rst)
        !op_valid |=> ($stable(acc) && $stable(carry_flag) && $stable(digit_carry_flag)
                      && $stable(zero_flag));
    endproperty
    a_idle_hold: assert property (p_idle_hold) else $error("state moved while idle");

    property p_reset_state;
        @(posedge clk_sys)
        rst |=> (acc == SXSALU_ACC_RST && file_waddr == 7'h00 && file_wdata == SXSALU_ZERO_BYTE
                 && {zero_flag, digit_carry_flag, carry_flag} == SXSALU_FLAGS_RST && !file_we);
    endproperty
    a_reset_state: assert property (p_reset_state) else $error("reset state wrong");

    // ==========================================================
    // Coverage

    c_sub_zero: cover property (@(posedge clk_sys) disable iff (rst)
        op_valid && op == SXSALU_OP_SUB_ACC_FROM_FILE ##1 zero_flag);
    c_sub_borrow: cover property (@(posedge clk_sys) disable iff (rst)
        op_valid && op == SXSALU_OP_SUB_ACC_FROM_FILE ##1 !carry_flag);
    c_swap_file: cover property (@(posedge clk_sys) disable iff (rst)
        op_valid && op == SXSALU_OP_NIBBLE_SWAP_FILE && dest_file);
    c_xor_lit_zero: cover property (@(posedge clk_sys) disable iff (rst)
        op_valid && op == SXSALU_OP_XOR_LITERAL_ACC ##1 zero_flag);
    c_xor_file_zero: cover property (@(posedge clk_sys) disable iff (rst)
        op_valid && op == SXSALU_OP_XOR_ACC_FILE ##1 zero_flag);
endmodule : sxsalu_top

// ==== include/sxsalu_pkg.sv ====
/*
 * Package for the subtract / xor / swap execution datapath.
 * Assumes an 8-bit data path and a 7-bit file register address.
 */
package sxsalu_pkg;
    // ==========================================================
    // Widths
    localparam int SXSALU_DATA_W = 8;
    localparam int SXSALU_ADDR_W = 7;

    // ==========================================================
    // Flag positions in the flag vector {zero, digit carry, carry}
    localparam int SXSALU_FLAG_C = 0;
    localparam int SXSALU_FLAG_DIGIT_CARRY = 1;
    localparam int SXSALU_FLAG_Z = 2;

    // ==========================================================
    // Reset values
    localparam logic [7:0] SXSALU_ACC_RST = 8'h00;
    localparam logic [2:0] SXSALU_FLAGS_RST = 3'h0;
    localparam logic [7:0] SXSALU_ZERO_BYTE = 8'h00;

    // ==========================================================
    // Operations
    typedef enum logic [1:0] {
        SXSALU_OP_SUB_ACC_FROM_FILE,
        SXSALU_OP_XOR_LITERAL_ACC,
        SXSALU_OP_XOR_ACC_FILE,
        SXSALU_OP_NIBBLE_SWAP_FILE
    } sxsalu_op_t;
endpackage : sxsalu_pkg

// ==== src/sxsalu_core.sv ====
/*
 * Combinational result and flag unit of the datapath.
 * Assumes operands are stable for the cycle in which op_valid is high.
 */
`timescale 1ns/10ps

module sxsalu_core
    import sxsalu_pkg::*;
(
    input wire sxsalu_op_t op,
    input wire logic [7:0] acc,
    input wire logic [7:0] file_val,
    input wire logic [7:0] literal,
    input wire logic [2:0] flags_in,
    output logic [7:0] result,
    output logic [2:0] flags_out
);
    wire logic [8:0] sub_full;
    wire logic [4:0] sub_low;
    wire logic [7:0] xor_lit;
    wire logic [7:0] xor_file;
    wire logic [7:0] swapped;
    wire logic sub_c;
    wire logic sub_digit_carry;

    // ==========================================================
    // Arithmetic: file minus accumulator, two's complement
    assign sub_full = {1'b0, file_val} + {1'b0, ~acc} + 9'h001;
    assign sub_low = {1'b0, file_val[3:0]} + {1'b0, ~acc[3:0]} + 5'h01;
    assign sub_c = sub_full[8];
    assign sub_digit_carry = sub_low[4];
    assign xor_lit = acc ^ literal;
    assign xor_file = acc ^ file_val;
    assign swapped = {file_val[3:0], file_val[7:4]};

    // ==========================================================
    // Result and flag selection
    always_comb begin
        result = swapped;
        flags_out = flags_in;
        unique case (op)
            SXSALU_OP_SUB_ACC_FROM_FILE: begin
                result = sub_full[7:0];
                flags_out[SXSALU_FLAG_C] = sub_c;
                flags_out[SXSALU_FLAG_DIGIT_CARRY] = sub_digit_carry;
                flags_out[SXSALU_FLAG_Z] = (sub_full[7:0] == SXSALU_ZERO_BYTE);
            end
            SXSALU_OP_XOR_LITERAL_ACC: begin
                result = xor_lit;
                flags_out[SXSALU_FLAG_Z] = (xor_lit == SXSALU_ZERO_BYTE);
            end
            SXSALU_OP_XOR_ACC_FILE: begin
                result = xor_file;
                flags_out[SXSALU_FLAG_Z] = (xor_file == SXSALU_ZERO_BYTE);
            end
            SXSALU_OP_NIBBLE_SWAP_FILE: begin
                result = swapped;
            end
        endcase
    end
endmodule : sxsalu_core

// ==== dv/sxsalu_top_tb.sv ====
/*
 * Self-checking bench for the subtract / xor / swap datapath.
 * Assumes the bench plays the file register array and forwards values itself.
 */
`timescale 1ns/10ps

module sxsalu_top_tb
    import sxsalu_pkg::*;
;
    localparam sxsalu_op_t OP_SUB = SXSALU_OP_SUB_ACC_FROM_FILE;
    localparam sxsalu_op_t OP_XL = SXSALU_OP_XOR_LITERAL_ACC;
    localparam sxsalu_op_t OP_XF = SXSALU_OP_XOR_ACC_FILE;
    localparam sxsalu_op_t OP_SW = SXSALU_OP_NIBBLE_SWAP_FILE;
    logic clk_sys, rst, op_valid, dest_file, carry_flag, digit_carry_flag, zero_flag, file_we;
    sxsalu_op_t op;
    logic [6:0] file_addr, file_waddr, m_wa;
    logic [7:0] file_rdata, literal, acc, file_wdata, m_acc, m_wd;
    logic m_c, m_digit_carry, m_z;
    int error_cnt = 0;
    int samples_checked = 0;

    sxsalu_top dut (.clk_sys(clk_sys), .rst(rst), .op_valid(op_valid), .op(op),
        .dest_file(dest_file), .file_addr(file_addr), .file_rdata(file_rdata),
        .literal(literal), .acc(acc), .carry_flag(carry_flag),
        .digit_carry_flag(digit_carry_flag), .zero_flag(zero_flag), .file_we(file_we),
        .file_waddr(file_waddr), .file_wdata(file_wdata));

    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end

    // ==========================================================
    // Compare and verdict
    task automatic print_verdict();
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : print_verdict

    task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp_byte

    task automatic cmp_state();
        cmp_byte(acc, m_acc);
        cmp_byte({5'h00, zero_flag, digit_carry_flag, carry_flag},
                 {5'h00, m_z, m_digit_carry, m_c});
        cmp_byte({1'b0, file_waddr}, {1'b0, m_wa});
        cmp_byte(file_wdata, m_wd);
    endtask : cmp_state

    // ==========================================================
    // One instruction, expectation worked out here
    task automatic step(input sxsalu_op_t o, input logic d, input logic [6:0] a,
                        input logic [7:0] fv, input logic [7:0] lit);
        logic [7:0] r;
        logic wr;
        op_valid = 1'b1;
        op = o;
        dest_file = d;
        file_addr = a;
        file_rdata = fv;
        literal = lit;
        wr = d && (o != OP_XL);
        r = (o == OP_SUB) ? fv - m_acc : (o == OP_XL) ? m_acc ^ lit :
            (o == OP_XF) ? m_acc ^ fv : {fv[3:0], fv[7:4]};
        if (o == OP_SUB) begin
            m_c = (m_acc <= fv);
            m_digit_carry = (m_acc[3:0] <= fv[3:0]);
        end
        if (o != OP_SW) begin
            m_z = (r == 8'h00);
        end
        if (wr) begin
            m_wa = a;
            m_wd = r;
        end else begin
            m_acc = r;
        end
        @(posedge clk_sys);
        #1;
        cmp_state();
        cmp_byte({7'h00, file_we}, {7'h00, wr});
    endtask : step

    // ==========================================================
    // Scenarios
    task automatic sc_sub();
        step(OP_XL, 1'b0, 7'h00, 8'h00, 8'h03);
        step(OP_SUB, 1'b1, 7'h10, 8'h05, 8'h00);
        step(OP_SUB, 1'b0, 7'h7F, 8'h03, 8'h00);
        step(OP_XL, 1'b0, 7'h00, 8'h00, 8'h1F);
        step(OP_SUB, 1'b0, 7'h01, 8'h20, 8'h00);
        step(OP_SUB, 1'b0, 7'h02, 8'hF0, 8'h00);
    endtask : sc_sub

    task automatic sc_xor();
        step(OP_XL, 1'b1, 7'h05, 8'hAA, 8'h01);
        step(OP_XF, 1'b1, 7'h20, 8'h5A, 8'h00);
        step(OP_XF, 1'b0, 7'h21, 8'h3C, 8'h00);
        step(OP_XF, 1'b0, 7'h22, 8'hD2, 8'h00);
    endtask : sc_xor

    task automatic sc_swap();
        step(OP_XL, 1'b0, 7'h00, 8'h00, 8'h21);
        step(OP_SUB, 1'b1, 7'h30, 8'h13, 8'h00);
        step(OP_SW, 1'b1, 7'h31, 8'hA5, 8'h00);
        step(OP_SW, 1'b0, 7'h32, 8'h0F, 8'h00);
        step(OP_SW, 1'b0, 7'h33, 8'h00, 8'h00);
    endtask : sc_swap

    task automatic sc_idle();
        op_valid = 1'b0;
        file_rdata = 8'h77;
        literal = 8'hFF;
        repeat (2) @(posedge clk_sys);
        #1;
        cmp_state();
        cmp_byte({7'h00, file_we}, 8'h00);
    endtask : sc_idle

    task automatic sc_reset();
        rst = 1'b1;
        repeat (2) @(posedge clk_sys);
        #1;
        rst = 1'b0;
        op_valid = 1'b0;
        {m_acc, m_wd, m_wa} = {SXSALU_ACC_RST, SXSALU_ZERO_BYTE, 7'h00};
        {m_z, m_digit_carry, m_c} = SXSALU_FLAGS_RST;
        cmp_state();
        cmp_byte({7'h00, file_we}, 8'h00);
    endtask : sc_reset

    initial begin
        {rst, op_valid, dest_file} = 3'h4;
        op = OP_SUB;
        file_addr = 7'h00;
        {file_rdata, literal} = 16'h0000;
        {m_acc, m_wd, m_wa} = {SXSALU_ACC_RST, SXSALU_ZERO_BYTE, 7'h00};
        {m_z, m_digit_carry, m_c} = SXSALU_FLAGS_RST;
        repeat (12) @(posedge clk_sys);
        #1;
        rst = 1'b0;
        cmp_state();
        sc_sub();
        sc_idle();
        sc_xor();
        sc_swap();
        sc_reset();
        step(OP_XL, 1'b0, 7'h00, 8'h00, 8'h5A);
        sc_idle();
        print_verdict();
    end

    initial begin
        repeat (500) @(posedge clk_sys);
        error_cnt++;
        print_verdict();
    end
endmodule : sxsalu_top_tb
